// ===== core/shifter_mantissa_align_op_pkg.sv
// shared widths, encodings and constants for the normalization path
package shifter_mantissa_align_op_pkg;

  // datapath widths
  localparam int WORD_W     = 16;
  localparam int RESULT_W   = 32;
  localparam int EXPONENT_W = 8;
  localparam int COUNT_W    = 5;

  // exponent figures of the detector
  localparam logic signed [EXPONENT_W-1:0] EXPONENT_ALL_SIGN   = -8'sd15;
  localparam logic signed [EXPONENT_W-1:0] EXPONENT_OVERFLOW   = 8'sd1;
  localparam logic signed [EXPONENT_W-1:0] EXPONENT_RESET      = 8'sh00;
  localparam logic signed [EXPONENT_W-1:0] EXPONENT_ONE        = 8'sd1;
  // a shift of this many places or more leaves nothing in the field
  localparam logic [EXPONENT_W-1:0]        SHIFT_OFF_SCALE     = 8'h20;

  // reset contents of the result register
  localparam logic [RESULT_W-1:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0]   HALF_ZERO    = 16'h0000;

  // bit positions inside the result register
  localparam int UPPER_MSB = 31;
  localparam int UPPER_LSB = 16;
  localparam int LOWER_MSB = 15;
  localparam int LOWER_LSB = 0;
  localparam int SIGN_BIT  = 15;

  // operation requested by the instruction sequencer
  typedef enum logic [1:0] {
    OP_IDLE   = 2'b00,
    OP_DERIVE = 2'b01,
    OP_ALIGN  = 2'b10,
    OP_LOAD   = 2'b11
  } op_t;

  // half modifier of the operation
  typedef enum logic [1:0] {
    TOP_HALF_MODE      = 2'b00,
    BOTTOM_HALF_MODE   = 2'b01,
    UPPER_EXTENDED_MODE = 2'b10,
    MODE_UNUSED        = 2'b11
  } half_mode_t;

  // operand source of the shifter
  typedef enum logic [2:0] {
    SRC_SHIFTER_INPUT = 3'b000,
    SRC_ALU_RESULT    = 3'b001,
    SRC_MULT_WORD0    = 3'b010,
    SRC_MULT_WORD1    = 3'b011,
    SRC_MULT_WORD2    = 3'b100,
    SRC_RESULT_LOW    = 3'b101,
    SRC_RESULT_UPPER  = 3'b110,
    SRC_UNUSED        = 3'b111
  } source_t;

endpackage

// ===== core/sign_run_counter.sv
// counts the run of leading bits that equal a given sign bit
`timescale 1ns/100ps

module sign_run_counter #(
  parameter int WIDTH   = 16,
  parameter int COUNT_W = 5
) (
  // operand
  input  wire logic [WIDTH-1:0]   value,
  input  wire logic               sign,
  // run length from the top, 0 to WIDTH
  output logic      [COUNT_W-1:0] run_count
);

  // the count must be able to hold WIDTH itself
  generate
    if ((1 << COUNT_W) <= WIDTH) begin : g_width_check
      $error("sign_run_counter: COUNT_W too small for WIDTH");
    end
  endgenerate

  // walk down from the top and stop at the first differing bit
  always_comb begin
    logic run;
    run       = 1'b1;
    run_count = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (run && (value[i] == sign)) begin
        run_count = COUNT_W'(run_count + 1'b1);
      end else begin
        run = 1'b0;
      end
    end
  end

endmodule

// ===== core/shifter_normalize_unit.sv
// exponent derivation and mantissa alignment of the fixed-point shifter
//
// Behaviour
// - normalize moves rightmost sign bit to field top, negated count is exponent
// - derive op detects exponent, writes it, honours top or bottom half mode
// - align op shifts by negated exponent; negative exponent shifts left
// - align op accepts top, bottom half modes and the or option
// - single word: top half mode fills upper result, bottom fills low
// - bottom half derive changes exponent only when it holds -15
// - all-sign upper half gives -15; then lower half sets final exponent
// - exponent of -16 or below shifts a top half input entirely out
// - extended mode without overflow acts as top half mode
// - extension bit is carry flag in top half, zero in bottom half
// - or option ors shifted value into result, else result is replaced
// - half modes place the shift in upper or lower result half
// - sources: shifter, alu, multiplier, result halves; output to result
`timescale 1ns/100ps

module shifter_normalize_unit
  import shifter_mantissa_align_op_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // operation request from the sequencer
  input  wire logic                              op_valid,
  input  shifter_mantissa_align_op_pkg::op_t                  op_code,
  input  shifter_mantissa_align_op_pkg::half_mode_t           half_mode,
  input  wire logic                              or_into_result_option,
  input  shifter_mantissa_align_op_pkg::source_t              src_sel,
  // operand words
  input  wire logic [DATA_W-1:0]                 shifter_input_reg,
  input  wire logic [DATA_W-1:0]                 alu_result_reg,
  input  wire logic [DATA_W-1:0]                 mult_result_word0,
  input  wire logic [DATA_W-1:0]                 mult_result_word1,
  input  wire logic [DATA_W-1:0]                 mult_result_word2,
  // status flags of the alu
  input  wire logic                              alu_overflow_flag,
  input  wire logic                              alu_carry_flag,
  // direct exponent load
  input  wire logic [shifter_mantissa_align_op_pkg::EXPONENT_W-1:0] exponent_load_value,
  // results
  output logic [shifter_mantissa_align_op_pkg::EXPONENT_W-1:0] shift_exponent_reg,
  output logic [shifter_mantissa_align_op_pkg::RESULT_W-1:0]   shift_result_reg,
  output logic                                    op_done
);

  import shifter_mantissa_align_op_pkg::*;

  // the detector and the half placement are built for a 16-bit word
  generate
    if (DATA_W != WORD_W) begin : g_width_check
      $error("shifter_normalize_unit: DATA_W must be 16");
    end
    if (EXPONENT_W <= COUNT_W) begin : g_exponent_check
      $error("shifter_normalize_unit: exponent cannot reach -31");
    end
    if (SHIFT_OFF_SCALE > (1 << COUNT_W)) begin : g_scale_check
      $error("shifter_normalize_unit: off-scale limit above shift range");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // shift a placed 32-bit field by a signed amount, left when positive;
  // right shifts fill with the extension bit, far right shifts give all fill, far left shifts give zero;
  // the amount is one bit wider than the exponent so +128 stays a left shift
  function automatic logic [RESULT_W-1:0] align_shift(
    input logic [RESULT_W-1:0]        placed,
    input logic                       ext,
    input logic signed [EXPONENT_W:0] amount
  );
    logic [2*RESULT_W-1:0] wide;
    logic [EXPONENT_W:0]   mag;
    logic [RESULT_W-1:0]   shifted;
    wide    = '0;
    mag     = '0;
    shifted = '0;
    if (amount >= 0) begin
      mag = amount;
      if (mag >= SHIFT_OFF_SCALE) begin
        shifted = '0;
      end else begin
        shifted = placed << mag[COUNT_W-1:0];
      end
    end else begin
      mag  = (EXPONENT_W+1)'(-amount);
      wide = {{RESULT_W{ext}}, placed};
      if (mag >= SHIFT_OFF_SCALE) begin
        shifted = {RESULT_W{ext}};
      end else begin
        wide    = wide >> mag[COUNT_W-1:0];
        shifted = wide[RESULT_W-1:0];
      end
    end
    return shifted;
  endfunction

  // place a word in the upper or lower half of the result field
  function automatic logic [RESULT_W-1:0] place_word(
    input logic [WORD_W-1:0] word,
    input logic              to_upper
  );
    logic [RESULT_W-1:0] placed;
    placed = to_upper ? {word, HALF_ZERO} : {HALF_ZERO, word};
    return placed;
  endfunction

  // widen an unsigned run length to a signed exponent operand
  function automatic logic signed [EXPONENT_W-1:0] run_to_exponent(
    input logic [COUNT_W-1:0] run_len
  );
    logic signed [EXPONENT_W-1:0] widened;
    widened = $signed({{(EXPONENT_W-COUNT_W){1'b0}}, run_len});
    return widened;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // operand selection

  // selected operand and the two halves of the result
  logic [WORD_W-1:0] operand;
  logic [WORD_W-1:0] result_upper_half;
  logic [WORD_W-1:0] result_lower_half;

  assign result_upper_half = shift_result_reg[UPPER_MSB:UPPER_LSB];
  assign result_lower_half = shift_result_reg[LOWER_MSB:LOWER_LSB];

  // result halves feed back so multiword values can be reworked in place
  assign operand =
    (src_sel == SRC_SHIFTER_INPUT) ? shifter_input_reg :
    (src_sel == SRC_ALU_RESULT)    ? alu_result_reg :
    (src_sel == SRC_MULT_WORD0)    ? mult_result_word0 :
    (src_sel == SRC_MULT_WORD1)    ? mult_result_word1 :
    (src_sel == SRC_MULT_WORD2)    ? mult_result_word2 :
    (src_sel == SRC_RESULT_LOW)    ? result_lower_half :
    (src_sel == SRC_RESULT_UPPER)  ? result_upper_half :
                                     HALF_ZERO;

  //////////////////////////////////////////////////////////////////////////////
  // decode of the request

  // one strobe per operation, plus the half modifiers
  logic do_derive;
  logic do_align;
  logic do_load;
  logic mode_bottom;
  logic mode_extended;

  assign do_derive     = op_valid && (op_code == OP_DERIVE);
  assign do_align      = op_valid && (op_code == OP_ALIGN);
  assign do_load       = op_valid && (op_code == OP_LOAD);
  assign mode_bottom   = (half_mode == BOTTOM_HALF_MODE);
  assign mode_extended = (half_mode == UPPER_EXTENDED_MODE);

  //////////////////////////////////////////////////////////////////////////////
  // exponent detection

  // run lengths and the sign kept from the last upper half derive
  logic [COUNT_W-1:0] top_run;
  logic [COUNT_W-1:0] bottom_run;
  logic               upper_sign;

  // run of sign bits in the word taken as an upper half
  sign_run_counter #(
    .WIDTH   (WORD_W),
    .COUNT_W (COUNT_W)
  ) u_top_run (
    .value     (operand),
    .sign      (operand[SIGN_BIT]),
    .run_count (top_run)
  );

  // run in a lower half, measured against the sign kept from the upper half
  sign_run_counter #(
    .WIDTH   (WORD_W),
    .COUNT_W (COUNT_W)
  ) u_bottom_run (
    .value     (operand),
    .sign      (upper_sign),
    .run_count (bottom_run)
  );

  // candidate exponents of the three derive flavours
  logic signed [EXPONENT_W-1:0] top_exponent;
  logic signed [EXPONENT_W-1:0] extended_exponent;
  logic signed [EXPONENT_W-1:0] bottom_exponent;
  logic                         exponent_at_all_sign;

  // redundant sign bits are the run minus the true sign itself; an
  // all-sign word runs 16 and so lands on -15
  assign top_exponent = EXPONENT_ONE
                      - run_to_exponent(top_run);

  // an overflowed sum needs one place of downshift, the carry as sign
  assign extended_exponent =
    alu_overflow_flag ? EXPONENT_OVERFLOW :
                        top_exponent;

  // the lower half continues the count below the all-sign upper half
  assign bottom_exponent = EXPONENT_ALL_SIGN
                         - run_to_exponent(bottom_run);

  // -15 is the only value a lower half pass may refine
  assign exponent_at_all_sign =
    ($signed(shift_exponent_reg) == EXPONENT_ALL_SIGN);

  logic [EXPONENT_W-1:0] next_exponent;
  logic                  next_upper_sign;

  // a bottom half pass only refines an all-sign upper half; any other
  // value is already final, which is why the upper half must go first
  assign next_exponent =
    do_load              ? exponent_load_value :
    !do_derive           ? shift_exponent_reg :
    mode_extended        ? extended_exponent :
    !mode_bottom         ? top_exponent :
    exponent_at_all_sign ? bottom_exponent :
                           shift_exponent_reg;

  // sign of the upper half, kept for the lower half pass
  assign next_upper_sign =
    (do_derive && !mode_bottom) ?
      ((mode_extended && alu_overflow_flag) ? alu_carry_flag
                                            : operand[SIGN_BIT]) :
      upper_sign;

  //////////////////////////////////////////////////////////////////////////////
  // mantissa alignment

  // align controls, the shifted word and the merged result
  logic                         align_to_upper;
  logic                         extension_bit;
  logic signed [EXPONENT_W:0]   align_amount;
  logic [RESULT_W-1:0]          placed_operand;
  logic [RESULT_W-1:0]          shifted_operand;
  logic [RESULT_W-1:0]          merged_result;
  logic [RESULT_W-1:0]          next_result;

  // extended mode on an align is taken as the upper half
  assign align_to_upper =
    !mode_bottom;

  // carry fills from above in the upper half; lower half fills zero
  assign extension_bit =
    align_to_upper ? alu_carry_flag : 1'b0;

  // negated one bit wider: an 8-bit negate of -128 would wrap to a
  // downshift, while a negative exponent must always mean an upshift
  assign align_amount =
    -{shift_exponent_reg[EXPONENT_W-1], shift_exponent_reg};

  assign placed_operand =
    place_word(operand, align_to_upper);

  assign shifted_operand =
    align_shift(placed_operand, extension_bit, align_amount);

  // or option merges a second half into the first for double precision
  assign merged_result = shift_result_reg | shifted_operand;

  assign next_result =
    !do_align             ? shift_result_reg :
    or_into_result_option ? merged_result :
                            shifted_operand;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  // exponent and kept sign; update in the op cycle so the next op sees it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_exponent_reg <= EXPONENT_RESET;
      upper_sign         <= 1'b0;
    end else begin
      shift_exponent_reg <= next_exponent;
      upper_sign         <= next_upper_sign;
    end
  end

  // 32-bit result register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_result_reg <= RESULT_RESET;
    end else begin
      shift_result_reg <= next_result;
    end
  end

  // completion pulse, one cycle after any accepted operation; a refused
  // lower half refine still pulses so the sequencer can count every op
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_done <= 1'b0;
    end else begin
      op_done <= do_derive || do_align || do_load;
    end
  end

endmodule

// ===== verif/shifter_mantissa_align_op_asserts.sv
// port-level checks of the normalization unit
`timescale 1ns/100ps

module shifter_mantissa_align_op_asserts
  import shifter_mantissa_align_op_pkg::*;
(
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // request
  input wire logic                  op_valid,
  input shifter_mantissa_align_op_pkg::op_t      op_code,
  input shifter_mantissa_align_op_pkg::half_mode_t half_mode,
  input wire logic                  or_into_result_option,
  input shifter_mantissa_align_op_pkg::source_t  src_sel,
  input wire logic [15:0]           shifter_input_reg,
  input wire logic                  alu_overflow_flag,
  // results
  input wire logic [7:0]            shift_exponent_reg,
  input wire logic [31:0]           shift_result_reg,
  input wire logic                  op_done
);
  // decoded request and signed view of the exponent
  wire go  = op_valid && op_code != OP_IDLE;
  wire der = op_valid && op_code == OP_DERIVE;
  wire aln = op_valid && op_code == OP_ALIGN;
  wire top = half_mode != BOTTOM_HALF_MODE;
  wire orx = or_into_result_option;
  wire signed [7:0] e = shift_exponent_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  a_done_pulse: assert property (go |=> op_done)
    else $error("op_done missing after an op");
  a_done_only: assert property (!go |=> !op_done)
    else $error("op_done without an op");
  a_align_exp: assert property (aln |=> $stable(shift_exponent_reg))
    else $error("align changed the exponent");
  a_derive_res: assert property (der |=> $stable(shift_result_reg))
    else $error("derive changed the result");
  a_bottom_hold: assert property (der && !top && e != -15
    |=> $stable(shift_exponent_reg)) else $error("bottom derive moved exp");
  a_all_sign: assert property (der && half_mode == TOP_HALF_MODE
    && src_sel == SRC_SHIFTER_INPUT && (&shifter_input_reg
    || ~|shifter_input_reg) |=> e == -15) else $error("all-sign not -15");
  a_ovf_plus: assert property (der && half_mode == UPPER_EXTENDED_MODE
    && alu_overflow_flag |=> e == 1) else $error("overflow exp not +1");
  a_or_keep: assert property (aln && orx |=> (shift_result_reg
    & $past(shift_result_reg)) == $past(shift_result_reg))
    else $error("or option lost result bits");
  a_off_scale: assert property (aln && top && !orx && e < -15
    |=> shift_result_reg == 32'h0000_0000) else $error("top not off scale");
  a_low_place: assert property (aln && !top && !orx && e >= 0
    |=> shift_result_reg[31:16] == 16'h0000) else $error("low half leaked");

  // main scenarios reached
  c_low_ext: cover property (der && !top && e == -15);
  c_or: cover property (aln && orx);
  c_ovf: cover property (der && half_mode == UPPER_EXTENDED_MODE
    && alu_overflow_flag);
endmodule

bind shifter_normalize_unit shifter_mantissa_align_op_asserts u_chk (.clk, .rst_n,
  .op_valid, .op_code, .half_mode, .or_into_result_option, .src_sel,
  .shifter_input_reg, .alu_overflow_flag, .shift_exponent_reg,
  .shift_result_reg, .op_done);

// ===== verif/alu_status_model.sv
// alu side model: result word and status flags seen by the shifter
`timescale 1ns/100ps

module alu_status_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // new alu outcome from the bench
  input  wire logic        load,
  input  wire logic [15:0] new_value,
  input  wire logic        new_ovf,
  input  wire logic        new_cy,
  // levels held between alu ops, like real status
  output logic      [15:0] alu_value,
  output logic             ovf,
  output logic             cy
);
  // flags only move on an alu op, so a shift op sees them stable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_value <= 16'h0000;
      ovf       <= 1'b0;
      cy        <= 1'b0;
    end else if (load) begin
      alu_value <= new_value;
      ovf       <= new_ovf;
      cy        <= new_cy;
    end
  end
endmodule

// ===== verif/tb.sv
// self-checking bench of the normalization unit
`timescale 1ns/100ps

module tb;
  import shifter_mantissa_align_op_pkg::*;
  logic       clk = 0, rst_n = 0, op_valid = 0, orx = 0;
  op_t        op_code = OP_IDLE;
  half_mode_t half_mode = TOP_HALF_MODE;
  source_t    src_sel = SRC_SHIFTER_INPUT;
  logic [15:0] si = 0, m0 = 0, m1 = 0, m2 = 0, n_val = 0;
  logic [7:0]  ld = 0;
  logic        load = 0, n_ovf = 0, n_cy = 0, kept = 0;
  wire  [15:0] alu_v;
  wire         ovf, cy, done;
  wire  [7:0]  se;
  wire  [31:0] sr;
  int          bad_count = 0, checks = 0;
  logic [31:0] seed = 32'hD9B80FAF, r, q;
  logic signed [7:0] e_e = 0;
  logic [31:0] e_r = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  alu_status_model ALU (.clk, .rst_n, .load, .new_value(n_val),
    .new_ovf(n_ovf), .new_cy(n_cy), .alu_value(alu_v), .ovf, .cy);
  shifter_normalize_unit #(.DATA_W(16)) DUT (.clk, .rst_n, .op_valid,
    .op_code, .half_mode, .or_into_result_option(orx), .src_sel,
    .shifter_input_reg(si), .alu_result_reg(alu_v),
    .mult_result_word0(m0), .mult_result_word1(m1),
    .mult_result_word2(m2), .alu_overflow_flag(ovf),
    .alu_carry_flag(cy), .exponent_load_value(ld),
    .shift_exponent_reg(se), .shift_result_reg(sr), .op_done(done));

  ////////////////////////////////////////////////////////////////////////
  // lfsr stimulus and reference functions
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic int run(logic [15:0] w, logic s);
    int n;
    n = 0;
    while (n < 16 && w[15-n] == s) n++;
    return n;
  endfunction
  // int amount avoids the -128 wrap of an 8-bit negate
  function automatic logic [31:0] shf(logic [15:0] w, logic bot,
                                      logic x, int a);
    logic [31:0] p;
    p = bot ? {16'h0000, w} : {w, 16'h0000};
    if (a >= 32) return 32'h0000_0000;
    if (a >= 0) return p << a;
    if (a <= -32) return {32{x}};
    return (p >> -a) | ~(32'hFFFF_FFFF >> -a) & {32{x}};
  endfunction
  function automatic logic [15:0] opnd(source_t s);
    case (s)
      SRC_SHIFTER_INPUT: return si;
      SRC_ALU_RESULT:    return alu_v;
      SRC_MULT_WORD0:    return m0;
      SRC_MULT_WORD1:    return m1;
      SRC_MULT_WORD2:    return m2;
      SRC_RESULT_LOW:    return e_r[15:0];
      SRC_RESULT_UPPER:  return e_r[31:16];
      default:           return 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    checks++;
    if (got !== ex) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one alu op; the shifter idles meanwhile
  task automatic alu(logic [15:0] v, logic o, logic c);
    op_valid = 0;
    load = 1;
    n_val = v;
    n_ovf = o;
    n_cy = c;
    @(posedge clk);
    #1 load = 0;
  endtask
  task automatic op(op_t c, half_mode_t m, logic o, source_t s);
    logic [15:0] w;
    logic        bot;
    w = opnd(s);
    bot = (m == BOTTOM_HALF_MODE);
    op_valid = 1'b1;
    op_code = c;
    half_mode = m;
    orx = o;
    src_sel = s;
    if (c == OP_DERIVE && m == UPPER_EXTENDED_MODE && ovf)
      {e_e, kept} = {8'sh01, cy};
    else if (c == OP_DERIVE && !bot)
      {e_e, kept} = {8'(1 - run(w, w[15])), w[15]};
    else if (c == OP_DERIVE && e_e == -15)
      e_e = 8'(-15 - run(w, kept));
    else if (c == OP_ALIGN)
      e_r = (o ? e_r : 0) | shf(w, bot, !bot && cy, -int'(e_e));
    else if (c == OP_LOAD)
      e_e = ld;
    @(posedge clk);
    #1 chk("op_done", 1, done);
    chk("exponent", {24'h0, e_e}, {24'h0, se});
    chk("result", e_r, sr);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // hang guard, well beyond the ~630 cycles of the run
  initial begin
    #50000;
    bad_count++;
    close_out();
  end

  // directed corners, then random ops
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    alu(16'hF6D0, 0, 0);
    op(OP_DERIVE, TOP_HALF_MODE, 0, SRC_ALU_RESULT);
    si = 16'h6ECB;
    op(OP_DERIVE, BOTTOM_HALF_MODE, 0, SRC_SHIFTER_INPUT);
    si = 16'hF6D4;
    op(OP_ALIGN, TOP_HALF_MODE, 0, SRC_SHIFTER_INPUT);
    chk("single", 32'hB6A0_0000, sr);
    si = 16'h6ECB;
    op(OP_ALIGN, BOTTOM_HALF_MODE, 1, SRC_SHIFTER_INPUT);
    chk("double", 32'hB6A3_7658, sr);
    $display("test double done");
    si = 16'hFFFF;
    op(OP_DERIVE, TOP_HALF_MODE, 0, SRC_SHIFTER_INPUT);
    m1 = 16'hF6D4;
    op(OP_DERIVE, BOTTOM_HALF_MODE, 0, SRC_MULT_WORD1);
    chk("extend", 32'h0000_00ED, {24'h0, se});
    op(OP_ALIGN, TOP_HALF_MODE, 0, SRC_SHIFTER_INPUT);
    op(OP_ALIGN, BOTTOM_HALF_MODE, 1, SRC_MULT_WORD1);
    chk("low", 32'hB6A0_0000, sr);
    $display("test all-sign done");
    alu(16'hFA32, 1, 0);
    op(OP_DERIVE, UPPER_EXTENDED_MODE, 0, SRC_ALU_RESULT);
    op(OP_ALIGN, TOP_HALF_MODE, 0, SRC_ALU_RESULT);
    chk("carry", 32'h7D19_0000, sr);
    alu(16'hE35B, 0, 1);
    op(OP_DERIVE, UPPER_EXTENDED_MODE, 0, SRC_ALU_RESULT);
    op(OP_ALIGN, UPPER_EXTENDED_MODE, 0, SRC_ALU_RESULT);
    $display("test extended done");
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      q = rnd();
      alu(r[15:0], r[16], r[17]);
      {si, m0} = q;
      {m1, m2} = {r[31:16], q[15:0] ^ r[15:0]};
      ld = (i % 7 == 0) ? 8'hF1 : q[7:0] ^ r[31:24];
      op(op_t'(2'(1 + r[20:19] % 3)), half_mode_t'(r[22:21]), r[23],
         source_t'(r[26:24]));
    end
    $display("test random done");
    {rst_n, op_valid, e_e, e_r, kept} = '0;
    @(posedge clk);
    #1 chk("reset res", 0, sr);
    chk("reset exp", 0, {24'h0, se});
    rst_n = 1;
    op(OP_ALIGN, BOTTOM_HALF_MODE, 1, SRC_MULT_WORD0);
    op_valid = 0;
    @(posedge clk);
    #1 chk("idle", 0, done);
    $display("test reset done");
    close_out();
  end
endmodule
